// ---- verilog/wdog_pkg.sv ----
// Purpose: Shared constants and state encoding for the refresh watchdog.
// Assumes: One 125 MHz clock; all timing is counted in timebase ticks.
// Notes:   Tick lengths and timeouts are plain defaults, tunable per build.
package wdog_pkg;
    // Core clock
    localparam int unsigned CLK_PERIOD_NS = 8;
    // Timebase tick period, in ns, and its length in clock cycles
    localparam int unsigned TICK_NS       = 1000;
    localparam int unsigned TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Counter width for timer, pulse width and reload value
    localparam int unsigned CNT_W         = 16;
    // Timeouts in ticks
    localparam logic [15:0] MAX_TIMEOUT_TICKS     = 16'h03e8;
    localparam logic [15:0] PROGRAM_THRESH_TICKS  = 16'h0064;
    localparam logic [15:0] RESET_PULSE_TICKS     = 16'h0032;
    // Reset values
    localparam logic [15:0] COUNT_CLEAR           = 16'h0000;
    localparam logic        RST_OUT_ASSERTED      = 1'b0;
    localparam logic        RST_OUT_RELEASED      = 1'b1;

    typedef enum logic [1:0] {
        ST_RESET,
        ST_WAIT_LOW,
        ST_COUNT,
        ST_HIGH
    } wd_state_t;
endpackage : wdog_pkg

// ---- verilog/tick_divider.sv ----
// Purpose: Free-running timebase; one-cycle tick every DIV clocks.
// Assumes: DIV is at least 1.
// Notes:   Runs through watchdog resets so timing never stalls.
`timescale 1ns/10ps
module tick_divider #(
    parameter int unsigned DIV = wdog_pkg::TICK_CYCLES
) (
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    output logic      tick
);
    import wdog_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             tick;
    } div_state_t;

    div_state_t s_q, s_d;

    // Count to DIV-1 then pulse; width-cast keeps the compare exact
    always_comb begin
        s_d      = s_q;
        s_d.tick = 1'b0;
        if (s_q.cnt >= CNT_W'(DIV - 1)) begin
            s_d.cnt  = COUNT_CLEAR;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + CNT_W'(1);
        end
    end

    // Timebase register [RULE_15]
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;
endmodule : tick_divider

// ---- verilog/refresh_sync.sv ----
// Purpose: Two-stage synchroniser and edge detector for the refresh pin.
// Assumes: Pin may change at any time relative to ref_clk.
// Notes:   Edges come from stages two and three; stage one feeds only two.
`timescale 1ns/10ps
module refresh_sync (
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    input  wire logic pin,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic last;
    } sync_state_t;

    sync_state_t s_q, s_d;

    // Shift chain only; no logic looks at the first stage
    always_comb begin
        s_d      = s_q;
        s_d.meta = pin;
        s_d.sync = s_q.meta;
        s_d.last = s_q.sync;
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Edge pulses after synchronisation [RULE_15]
    assign level = s_q.sync;
    assign rise  = s_q.sync & ~s_q.last;
    assign fall  = ~s_q.sync & s_q.last;
endmodule : refresh_sync

// ---- verilog/refresh_watchdog.sv ----
// Purpose: Watchdog that resets the host unless refresh pulses keep coming.
// Assumes: power_fault and inhibit_input are synchronous to ref_clk.
// Notes:   Timer counts elapsed ticks up toward the reload value.
//
// Functional notes
// RULE_01: Power-on reset and supply faults re-initialise the watchdog.
// RULE_02: Every refresh reloads the timer, whatever it held.
// RULE_03: Any reset restores reload value to maximum and reloads the timer.
// RULE_04: Counting starts after reset releases and only while refresh is low.
// RULE_05: Timeout before next refresh rise issues reset, reload back to maximum.
// RULE_06: Host pulses refresh periodically, before the programmed timeout.
// RULE_07: First refresh pulse between threshold and maximum is a programming pulse.
// RULE_08: Programming pulse loads timer and reload value with its width.
// RULE_09: Reload value is programmable once per reset.
// RULE_10: After programming, short pulses reload timer with programmed value.
// RULE_11: Falling refresh resumes counting up from reload start.
// RULE_12: Refresh held high past the reload time resets at once.
// RULE_13: Host drives refresh low on reset, avoiding reset ping-pong.
// RULE_14: Inhibit high suppresses all watchdog timeouts.
// RULE_15: Widths are measured in timebase ticks; refresh edges are synchronised.
`timescale 1ns/10ps
module refresh_watchdog #(
    parameter int unsigned      TICK_DIV    = wdog_pkg::TICK_CYCLES,
    parameter logic [15:0]      MAX_TICKS   = wdog_pkg::MAX_TIMEOUT_TICKS,
    parameter logic [15:0]      LOAD_TICKS  = wdog_pkg::PROGRAM_THRESH_TICKS,
    parameter logic [15:0]      RST_TICKS   = wdog_pkg::RESET_PULSE_TICKS
) (
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    input  wire logic power_fault,
    input  wire logic refresh_input,
    input  wire logic inhibit_input,
    output logic      reset_out_n,
    output logic      reload_programmed
);
    import wdog_pkg::*;

    typedef struct packed {
        wd_state_t        state;
        logic [CNT_W-1:0] timer;
        logic [CNT_W-1:0] high_cnt;
        logic [CNT_W-1:0] reload_value;
        logic [CNT_W-1:0] rst_cnt;
        logic             programmed;
        logic             rst_n;
    } wd_core_t;

    wd_core_t s_q, s_d;

    logic tick;
    logic ref_level;
    logic ref_rise;
    logic ref_fall;
    logic fire;
    logic [CNT_W-1:0] timer_next;
    logic [CNT_W-1:0] high_next;

    // Timebase [RULE_15]
    tick_divider #(
        .DIV     (TICK_DIV)
    ) u_tick (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .tick    (tick)
    );

    // Refresh pin conditioning [RULE_15]
    refresh_sync u_sync (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .pin     (refresh_input),
        .level   (ref_level),
        .rise    (ref_rise),
        .fall    (ref_fall)
    );

    // Reset entry: reload to maximum, programming window reopened
    function automatic wd_core_t enter_reset(input wd_core_t cur);
        wd_core_t r;
        r              = cur;
        r.state        = ST_RESET;
        r.rst_n        = RST_OUT_ASSERTED;
        r.rst_cnt      = COUNT_CLEAR;
        r.timer        = COUNT_CLEAR;
        r.high_cnt     = COUNT_CLEAR;
        r.reload_value = MAX_TICKS;  // [RULE_03]
        r.programmed   = 1'b0;       // [RULE_09]
        return r;
    endfunction : enter_reset

    assign timer_next = s_q.timer + CNT_W'(1);
    assign high_next  = s_q.high_cnt + CNT_W'(1);

    // Next-state logic
    always_comb begin
        s_d  = s_q;
        fire = 1'b0;
        unique case (s_q.state)
            ST_RESET: begin
                // Hold reset low for the pulse length, then release
                if (tick) begin
                    if (s_q.rst_cnt >= RST_TICKS - CNT_W'(1)) begin
                        s_d.rst_n   = RST_OUT_RELEASED;
                        s_d.rst_cnt = COUNT_CLEAR;
                        s_d.state   = ST_WAIT_LOW;
                    end else begin
                        s_d.rst_cnt = s_q.rst_cnt + CNT_W'(1);
                    end
                end
            end
            ST_WAIT_LOW: begin
                // No counting until refresh is seen low [RULE_04]
                if (!ref_level) begin
                    s_d.state = ST_COUNT;
                end
            end
            ST_COUNT: begin
                if (ref_rise) begin
                    s_d.timer    = COUNT_CLEAR;  // [RULE_02]
                    s_d.high_cnt = COUNT_CLEAR;
                    s_d.state    = ST_HIGH;
                end else if (tick) begin
                    if (timer_next >= s_q.reload_value) begin
                        fire = 1'b1;              // [RULE_05]
                    end else begin
                        s_d.timer = timer_next;   // [RULE_11]
                    end
                end
            end
            ST_HIGH: begin
                if (ref_fall) begin
                    // Only the first qualifying pulse programs [RULE_07] [RULE_09]
                    if (!s_q.programmed && s_q.high_cnt > LOAD_TICKS
                        && s_q.high_cnt < MAX_TICKS) begin
                        s_d.reload_value = s_q.high_cnt;  // [RULE_08]
                        s_d.programmed   = 1'b1;
                    end
                    s_d.timer = COUNT_CLEAR;  // [RULE_10]
                    s_d.state = ST_COUNT;     // [RULE_11]
                end else if (tick) begin
                    if (high_next > s_q.reload_value) begin
                        fire = 1'b1;          // [RULE_12]
                    end else begin
                        s_d.high_cnt = high_next;
                    end
                end
            end
        endcase
        // Inhibit only restarts the measurement, so counts stay bounded
        if (fire) begin
            if (inhibit_input) begin
                s_d.timer    = COUNT_CLEAR;  // [RULE_14]
                s_d.high_cnt = COUNT_CLEAR;
            end else begin
                s_d = enter_reset(s_q);      // [RULE_05]
            end
        end
        // Supply fault outranks everything [RULE_01]
        if (power_fault) begin
            s_d = enter_reset(s_q);
        end
    end

    // State register; power-on starts inside a reset pulse [RULE_01]
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_q.state        <= ST_RESET;
            s_q.timer        <= COUNT_CLEAR;
            s_q.high_cnt     <= COUNT_CLEAR;
            s_q.reload_value <= MAX_TICKS;
            s_q.rst_cnt      <= COUNT_CLEAR;
            s_q.programmed   <= 1'b0;
            s_q.rst_n        <= RST_OUT_ASSERTED;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flops
    assign reset_out_n       = s_q.rst_n;
    assign reload_programmed = s_q.programmed;

    // ---------------- Assertions ----------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence s_timeout_hit;
        s_q.state == ST_COUNT && !ref_rise && tick
            && timer_next >= s_q.reload_value && !inhibit_input;
    endsequence

    sequence s_prog_fall;
        s_q.state == ST_HIGH && ref_fall && !s_q.programmed
            && s_q.high_cnt > LOAD_TICKS && s_q.high_cnt < MAX_TICKS
            && !power_fault;
    endsequence

    sequence s_plain_fall;
        s_q.state == ST_HIGH && ref_fall && s_q.programmed && !power_fault;
    endsequence

    sequence s_overlong;
        s_q.state == ST_HIGH && !ref_fall && tick
            && high_next > s_q.reload_value && !inhibit_input
            && !power_fault;
    endsequence

    chk_fault_reinit: assert property ( // [RULE_01]
        power_fault |=> s_q.state == ST_RESET && !reset_out_n
            && s_q.reload_value == MAX_TICKS)
        else $error("fault did not re-initialise watchdog");

    chk_refresh_reload: assert property ( // [RULE_02]
        s_q.state == ST_COUNT && ref_rise |=> s_q.timer == COUNT_CLEAR)
        else $error("refresh rise did not clear timer");

    chk_reset_restore: assert property ( // [RULE_03]
        s_q.state == ST_RESET |-> s_q.reload_value == MAX_TICKS
            && !s_q.programmed && !reset_out_n)
        else $error("reset state without maximum reload");

    chk_count_gate: assert property ( // [RULE_04]
        s_q.timer != $past(s_q.timer) && s_q.timer != COUNT_CLEAR
            |-> $past(s_q.state) == ST_COUNT && $past(s_q.rst_n))
        else $error("timer advanced outside counting state");

    chk_timeout_reset: assert property ( // [RULE_05]
        s_timeout_hit |=> !reset_out_n && s_q.reload_value == MAX_TICKS)
        else $error("timeout did not issue reset");

    chk_program_load: assert property ( // [RULE_08]
        s_prog_fall |=> s_q.programmed
            && s_q.reload_value == $past(s_q.high_cnt)
            && s_q.timer == COUNT_CLEAR)
        else $error("programming pulse not loaded");

    chk_program_once: assert property ( // [RULE_09]
        s_q.programmed && !power_fault && s_q.state != ST_RESET
            ##1 s_q.state != ST_RESET |-> $stable(s_q.reload_value))
        else $error("reload value changed after programming");

    chk_plain_refresh: assert property ( // [RULE_10]
        s_plain_fall |=> s_q.state == ST_COUNT && $stable(s_q.reload_value)
            && s_q.timer == COUNT_CLEAR)
        else $error("refresh after programming misbehaved");

    chk_overlong_high: assert property ( // [RULE_12]
        s_overlong |=> !reset_out_n ##1 !reset_out_n)
        else $error("long refresh did not reset");

    chk_inhibit_hold: assert property ( // [RULE_14]
        inhibit_input && reset_out_n && !power_fault |=> reset_out_n)
        else $error("reset issued while inhibited");

    chk_reset_length: assert property ( // [RULE_05]
        $fell(reset_out_n) && s_q.state == ST_RESET
            |-> !reset_out_n [*8])
        else $error("reset pulse too short");
endmodule : refresh_watchdog

// ---- testbench/host_model.sv ----
// Purpose: Host stand-in that drives the refresh pin and obeys reset.
// Assumes: Bench calls the tasks; pin changes land just after ref_clk rises.
// Notes:   Push-pull pin, so it never floats or holds a stale value.
`timescale 1ns/10ps
module host_model (
    input  wire logic ref_clk,
    input  wire logic reset_out_n,
    output logic      refresh_input
);
    initial refresh_input = 1'b0;

    // Pin forced low under reset, else host and watchdog could ping-pong
    always @(posedge ref_clk) begin
        if (reset_out_n === 1'b0) refresh_input <= 1'b0;
    end

    // Raise and leave high; the caller (as in pulse) or a reset brings it down again
    task automatic raise();
        @(posedge ref_clk);
        refresh_input <= 1'b1;
    endtask : raise

    // One pulse of cyc clocks, sent before the timeout runs out
    task automatic pulse(input int cyc);
        raise();
        repeat (cyc) @(posedge ref_clk);
        refresh_input <= 1'b0;
    endtask : pulse
endmodule : host_model

// ---- testbench/refresh_watchdog_test.sv ----
// Purpose: Self-checking bench for the refresh watchdog.
// Assumes: Shortened counts; tick every DIV clocks.
// Notes:   Widths are tick-quantised, so windows allow a tick plus sync lag.
`timescale 1ns/10ps
module refresh_watchdog_test;
    localparam int DIV  = 2;
    localparam int MAXT = 40;
    localparam int RSTT = 8;
    localparam int PT   = 10;
    localparam int MAXC = MAXT * DIV;

    logic ref_clk;
    logic sys_rst;
    logic power_fault;
    logic inhibit_input;
    logic refresh_input;
    logic reset_out_n;
    logic reload_programmed;
    int   err_count;
    int   tests_run;
    int   n;

    // 125 MHz clock
    always #4 ref_clk = ~ref_clk;

    refresh_watchdog #(.TICK_DIV(DIV), .MAX_TICKS(16'(MAXT)), .LOAD_TICKS(16'h0005),
        .RST_TICKS(16'(RSTT))) uut (
        .ref_clk          (ref_clk),
        .sys_rst          (sys_rst),
        .power_fault      (power_fault),
        .refresh_input    (refresh_input),
        .inhibit_input    (inhibit_input),
        .reset_out_n      (reset_out_n),
        .reload_programmed(reload_programmed)
    );

    host_model host (
        .ref_clk      (ref_clk),
        .reset_out_n  (reset_out_n),
        .refresh_input(refresh_input)
    );

    task automatic finish_test();
        if (err_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test

    task automatic check_bit(input logic got, input logic exp, input string what);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t %s: got %b", $time, what, got);
        end
    endtask : check_bit

    task automatic check_span(input int got, input int lo, input int hi, input string what);
        tests_run++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("[ERR] %0t %s: %0d cycles, not %0d..%0d", $time, what, got, lo, hi);
        end
    endtask : check_span

    // Bounded wait for reset_out_n, sampled at falling edges
    task automatic wait_rst(input logic v, input int bound, output int cnt);
        cnt = 0;
        while (reset_out_n !== v) begin
            @(negedge ref_clk);
            cnt++;
            if (cnt > bound) begin
                err_count++;
                $display("[ERR] %0t reset_out_n never reached %b", $time, v);
                finish_test();
            end
        end
    endtask : wait_rst

    task automatic t_power_on();
        repeat (6) @(posedge ref_clk);
        check_bit(reset_out_n, 1'b0, "reset low in reset");
        check_bit(reload_programmed, 1'b0, "programmed in reset");
        sys_rst <= 1'b0;
        wait_rst(1'b1, 100, n);
        check_span(n, RSTT * DIV - 4, RSTT * DIV + 4, "power-on pulse");
    endtask : t_power_on

    // Starts at reset release with refresh low
    task automatic t_timeout();
        wait_rst(1'b0, MAXC + 20, n);
        check_span(n, MAXC - 2, MAXC + 8, "max timeout");
        check_bit(reload_programmed, 1'b0, "reload back to max");
        wait_rst(1'b1, 100, n);
        check_span(n, RSTT * DIV - 4, RSTT * DIV + 4, "reset pulse");
    endtask : t_timeout

    task automatic t_keepalive();
        n = 0;
        repeat (6) begin
            host.pulse(4);
            repeat (50) begin
                @(negedge ref_clk);
                if (reset_out_n !== 1'b1) n++;
            end
        end
        check_span(n, 0, 0, "refreshed watchdog fired");
        check_bit(reload_programmed, 1'b0, "short pulse programmed");
    endtask : t_keepalive

    task automatic program_pulse(input int ticks);
        host.pulse(ticks * DIV);
        repeat (4) @(negedge ref_clk);
        check_bit(reload_programmed, 1'b1, "long pulse not taken");
    endtask : program_pulse

    task automatic t_short_reload();
        program_pulse(PT);
        wait_rst(1'b0, 200, n);
        check_span(n + 4, PT * DIV - 4, PT * DIV + 8, "programmed timeout");
        wait_rst(1'b1, 100, n);
        check_bit(reload_programmed, 1'b0, "programming survived reset");
        t_timeout();
    endtask : t_short_reload

    // Second, shorter qualifying pulse must not reprogram the longer value
    task automatic t_once();
        program_pulse(15);
        host.pulse(6 * DIV);
        wait_rst(1'b0, 200, n);
        check_span(n, 15 * DIV - 4, 15 * DIV + 12, "reprogrammed twice");
        wait_rst(1'b1, 100, n);
    endtask : t_once

    task automatic t_overlong();
        program_pulse(PT);
        host.raise();
        wait_rst(1'b0, 200, n);
        check_span(n, PT * DIV - 2, PT * DIV + 12, "overlong high");
        wait_rst(1'b1, 100, n);
    endtask : t_overlong

    task automatic t_inhibit();
        @(posedge ref_clk);
        inhibit_input <= 1'b1;
        n = 0;
        repeat (3 * MAXC) begin
            @(negedge ref_clk);
            if (reset_out_n !== 1'b1) n++;
        end
        check_span(n, 0, 0, "inhibited reset");
        @(posedge ref_clk);
        inhibit_input <= 1'b0;
        wait_rst(1'b0, MAXC + 20, n);
        check_span(n, 1, MAXC + 8, "timeout after inhibit");
        wait_rst(1'b1, 100, n);
    endtask : t_inhibit

    task automatic t_fault();
        program_pulse(PT);
        @(posedge ref_clk);
        power_fault <= 1'b1;
        @(posedge ref_clk);
        power_fault <= 1'b0;
        wait_rst(1'b0, 3, n);
        check_bit(reload_programmed, 1'b0, "fault kept programming");
        wait_rst(1'b1, 100, n);
        check_span(n, RSTT * DIV - 6, RSTT * DIV + 6, "fault reset pulse");
    endtask : t_fault

    // Main sequence
    initial begin
        ref_clk = 1'b0;
        sys_rst = 1'b1;
        power_fault = 1'b0;
        inhibit_input = 1'b0;
        err_count = 0;
        tests_run = 0;
        t_power_on();
        t_timeout();
        t_keepalive();
        t_short_reload();
        t_once();
        t_overlong();
        t_inhibit();
        t_fault();
        finish_test();
    end
endmodule : refresh_watchdog_test
